// ==== inc/bmsd_pkg.sv ====
// Constants and types for the reset-time boot selection decoder.
// Assumes a single system clock; straps are static around reset release.
//
// Operation
// - Break-in and test-mode straps are active low; one means not asserted.
// - Straps high, code 000: boot ROM loader over async serial, user at D4000000.
// - Straps high, code 001: serial bootstrap over CAN into scratch pad, run it.
// - Straps high, code 010: serial bootstrap over sync serial into scratch pad.
// - Straps high, code 011: external memory, bus unit master, user at A0000000.
// - Straps high, code 100: external memory, bus unit slave, same addresses.
// - Straps high, code 110: skip boot ROM, fetch from scratch pad at D4000000.
// - Straps high, codes 101 and 111 are reserved; device stops.
// - Test mode low, break-in high: all codes reserved, stop after boot ROM entry.
// - Break-in low, test high, code 000: tristate all pins.
// - Break-in low, test high, code 001: boot ROM then jump to emulator DE000000.
// - Break-in low, test high, code 011: bypass oscillator and PLL.
// - Both low, or break-in low with 010 or 100-111: reserved, stop.
`default_nettype none
package bmsd_pkg;

  // ==========================================================================
  // Boot actions
  typedef enum logic [3:0] {
    BMSD_ACT_BSL_ASYNC = 4'h0,
    BMSD_ACT_BSL_CAN   = 4'h1,
    BMSD_ACT_BSL_SYNC  = 4'h2,
    BMSD_ACT_EXT_MSTR  = 4'h3,
    BMSD_ACT_EXT_SLV   = 4'h4,
    BMSD_ACT_SCRATCH   = 4'h5,
    BMSD_ACT_EMUL      = 4'h6,
    BMSD_ACT_TRISTATE  = 4'h7,
    BMSD_ACT_BYPASS    = 4'h8,
    BMSD_ACT_STOP      = 4'h9
  } bmsd_action_t;

  // ==========================================================================
  // Configuration codes
  localparam logic [2:0] CFG_000 = 3'h0;
  localparam logic [2:0] CFG_001 = 3'h1;
  localparam logic [2:0] CFG_010 = 3'h2;
  localparam logic [2:0] CFG_011 = 3'h3;
  localparam logic [2:0] CFG_100 = 3'h4;
  localparam logic [2:0] CFG_110 = 3'h6;

  // ==========================================================================
  // Addresses
  localparam logic [31:0] ADDR_BOOT_ROM    = 32'hdffffffc;
  localparam logic [31:0] ADDR_STOP_ENTRY  = 32'hdfffffff;
  localparam logic [31:0] ADDR_SCRATCH     = 32'hd4000000;
  localparam logic [31:0] ADDR_EXT_MEM     = 32'ha0000000;
  localparam logic [31:0] ADDR_EMULATOR    = 32'hde000000;
  localparam logic [31:0] ADDR_NONE        = 32'h00000000;

  // Reset values
  localparam logic [3:0]  RST_ACTION = 4'h9;
  localparam logic [2:0]  RST_CFG    = 3'h0;
  localparam logic        RST_STRAP  = 1'b1;

endpackage
`default_nettype wire

// ==== hw/bmsd_top.sv ====
// Boot mode selection decoder: latches straps at reset release and decodes
// them into a boot action, boot ROM entry and user start address.
// Assumes straps are driven stable by the board while reset is low.
`timescale 1ns/100ps
`default_nettype none

module bmsd_top (
  input  wire logic        i_clk,                  // System clock, 125 MHz
  input  wire logic        i_rst_n,                // Async reset, active low
  input  wire logic        i_ce,                   // Clock enable
  input  wire logic        i_break_in_strap_n,     // Break-in strap, active low
  input  wire logic        i_test_mode_strap_n,    // Test-mode strap, active low
  input  wire logic [2:0]  i_hw_boot_config_code,  // Boot configuration strap field
  output logic             o_valid,                // Decode latched and valid
  output logic [3:0]       o_action,               // Decoded boot action
  output logic [31:0]      o_pc_start,             // First fetch address
  output logic [31:0]      o_user_entry,           // User program start address
  output logic             o_use_boot_rom,         // Boot ROM runs first
  output logic             o_bsl_async,            // Load over async serial channel
  output logic             o_bsl_can,              // Load over CAN
  output logic             o_bsl_sync,             // Load over sync serial channel
  output logic             o_ext_bus_master,       // External bus unit as master
  output logic             o_ext_bus_slave,        // External bus unit as slave
  output logic             o_tristate,             // Pins high impedance
  output logic             o_osc_pll_bypass,       // Oscillator and PLL bypass
  output logic             o_stop                  // Halt, no user code
);

  // ==========================================================================
  // Reset synchroniser
  logic rst_meta_r;
  logic rst_sync_r;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Strap capture
  logic        latched_r;
  logic        brk_n_r;
  logic        tm_n_r;
  logic [2:0]  cfg_r;

  // Capture straps once after release; held until next reset
  always_ff @(posedge i_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      latched_r <= 1'b0;
      brk_n_r   <= bmsd_pkg::RST_STRAP;
      tm_n_r    <= bmsd_pkg::RST_STRAP;
      cfg_r     <= bmsd_pkg::RST_CFG;
    end
    else if (i_ce && !latched_r)
    begin
      latched_r <= 1'b1;
      brk_n_r   <= i_break_in_strap_n;
      tm_n_r    <= i_test_mode_strap_n;
      cfg_r     <= i_hw_boot_config_code;
    end
  end

  // ==========================================================================
  // Decode
  bmsd_pkg::bmsd_action_t act_nxt;
  logic [31:0]            pc_nxt;
  logic [31:0]            user_nxt;
  logic                   rom_nxt;

  // Table lookup from latched straps; straps active low
  always_comb
  begin
    act_nxt  = bmsd_pkg::BMSD_ACT_STOP;
    pc_nxt   = bmsd_pkg::ADDR_NONE;
    user_nxt = bmsd_pkg::ADDR_NONE;
    rom_nxt  = 1'b0;
    if (brk_n_r && tm_n_r)
    begin
      case (cfg_r)
        bmsd_pkg::CFG_000:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_BSL_ASYNC;
          pc_nxt   = bmsd_pkg::ADDR_BOOT_ROM;
          user_nxt = bmsd_pkg::ADDR_SCRATCH;
          rom_nxt  = 1'b1;
        end
        bmsd_pkg::CFG_001:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_BSL_CAN;
          pc_nxt   = bmsd_pkg::ADDR_BOOT_ROM;
          user_nxt = bmsd_pkg::ADDR_SCRATCH;
          rom_nxt  = 1'b1;
        end
        bmsd_pkg::CFG_010:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_BSL_SYNC;
          pc_nxt   = bmsd_pkg::ADDR_BOOT_ROM;
          user_nxt = bmsd_pkg::ADDR_SCRATCH;
          rom_nxt  = 1'b1;
        end
        bmsd_pkg::CFG_011:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_EXT_MSTR;
          pc_nxt   = bmsd_pkg::ADDR_BOOT_ROM;
          user_nxt = bmsd_pkg::ADDR_EXT_MEM;
          rom_nxt  = 1'b1;
        end
        bmsd_pkg::CFG_100:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_EXT_SLV;
          pc_nxt   = bmsd_pkg::ADDR_BOOT_ROM;
          user_nxt = bmsd_pkg::ADDR_EXT_MEM;
          rom_nxt  = 1'b1;
        end
        bmsd_pkg::CFG_110:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_SCRATCH;
          pc_nxt   = bmsd_pkg::ADDR_SCRATCH;
          user_nxt = bmsd_pkg::ADDR_SCRATCH;
        end
        3'h7:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_STOP;
          pc_nxt   = bmsd_pkg::ADDR_BOOT_ROM;
          rom_nxt  = 1'b1;
        end
        default:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_STOP;
        end
      endcase
    end
    else if (brk_n_r && !tm_n_r)
    begin
      act_nxt  = bmsd_pkg::BMSD_ACT_STOP;
      pc_nxt   = bmsd_pkg::ADDR_BOOT_ROM;
      rom_nxt  = 1'b1;
    end
    else if (!brk_n_r && tm_n_r)
    begin
      case (cfg_r)
        bmsd_pkg::CFG_000:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_TRISTATE;
        end
        bmsd_pkg::CFG_001:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_EMUL;
          pc_nxt   = bmsd_pkg::ADDR_BOOT_ROM;
          user_nxt = bmsd_pkg::ADDR_EMULATOR;
          rom_nxt  = 1'b1;
        end
        bmsd_pkg::CFG_011:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_BYPASS;
        end
        bmsd_pkg::CFG_010:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_STOP;
        end
        default:
        begin
          act_nxt  = bmsd_pkg::BMSD_ACT_STOP;
          pc_nxt   = bmsd_pkg::ADDR_STOP_ENTRY;
          rom_nxt  = 1'b1;
        end
      endcase
    end
    else
    begin
      act_nxt  = bmsd_pkg::BMSD_ACT_STOP;
      pc_nxt   = bmsd_pkg::ADDR_STOP_ENTRY;
      rom_nxt  = 1'b1;
    end
  end

  // ==========================================================================
  // Registered outputs, all loaded one enabled edge after the capture
  logic        load_en;
  logic [7:0]  flag_r;

  // Outputs load on every enabled edge once the straps are held
  assign load_en = i_ce && latched_r;

  // Action that each flag bit stands for, in port order
  localparam bmsd_pkg::bmsd_action_t FLAG_ACT [8] = '{
    bmsd_pkg::BMSD_ACT_BSL_ASYNC,
    bmsd_pkg::BMSD_ACT_BSL_CAN,
    bmsd_pkg::BMSD_ACT_BSL_SYNC,
    bmsd_pkg::BMSD_ACT_EXT_MSTR,
    bmsd_pkg::BMSD_ACT_EXT_SLV,
    bmsd_pkg::BMSD_ACT_TRISTATE,
    bmsd_pkg::BMSD_ACT_BYPASS,
    bmsd_pkg::BMSD_ACT_STOP
  };

  // Valid rises with the first load and holds until the next reset
  always_ff @(posedge i_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_valid <= 1'b0;
    end
    else if (load_en)
    begin
      o_valid <= 1'b1;
    end
  end

  // Action code, parked at stop while in reset
  always_ff @(posedge i_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_action <= bmsd_pkg::RST_ACTION;
    end
    else if (load_en)
    begin
      o_action <= act_nxt;
    end
  end

  // First fetch address
  always_ff @(posedge i_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_pc_start <= bmsd_pkg::ADDR_NONE;
    end
    else if (load_en)
    begin
      o_pc_start <= pc_nxt;
    end
  end

  // User program start address
  always_ff @(posedge i_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_user_entry <= bmsd_pkg::ADDR_NONE;
    end
    else if (load_en)
    begin
      o_user_entry <= user_nxt;
    end
  end

  // Boot ROM runs ahead of the user program
  always_ff @(posedge i_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_use_boot_rom <= 1'b0;
    end
    else if (load_en)
    begin
      o_use_boot_rom <= rom_nxt;
    end
  end

  // ==========================================================================
  // One-hot action flags; all low for the scratch pad and emulator actions

  // One flop per flag, set when the decode picks its action
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_flag
    always_ff @(posedge i_clk or negedge rst_sync_r)
    begin
      if (!rst_sync_r)
      begin
        flag_r[gi] <= 1'b0;
      end
      else if (load_en)
      begin
        flag_r[gi] <= (act_nxt == FLAG_ACT[gi]);
      end
    end
  end

  // Flags leave straight from their flops
  assign o_bsl_async      = flag_r[0];
  assign o_bsl_can        = flag_r[1];
  assign o_bsl_sync       = flag_r[2];
  assign o_ext_bus_master = flag_r[3];
  assign o_ext_bus_slave  = flag_r[4];
  assign o_tristate       = flag_r[5];
  assign o_osc_pll_bypass = flag_r[6];
  assign o_stop           = flag_r[7];

endmodule

`default_nettype wire

// ==== tb/bmsd_straps.sv ====
// Board strap model for the boot selection decoder.
// Assumes the bench names the wanted straps while reset is low.
`timescale 1ns/100ps
`default_nettype none
module bmsd_straps (
  input  wire logic       i_clk,                 // Clock
  input  wire logic       i_rst_n,               // Board reset, low
  input  wire logic [4:0] i_want,                // Break-in, test, code
  input  wire logic       i_wiggle,              // Upset straps after capture
  output logic            o_break_in_strap_n,    // Break-in strap
  output logic            o_test_mode_strap_n,   // Test-mode strap
  output logic [2:0]      o_hw_boot_config_code  // Code strap
);
  logic [4:0] straps_r;
  // Straps follow the setting only in reset, then stay put unless upset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n) straps_r <= i_want;
    else if (i_wiggle) straps_r <= ~straps_r;
  end
  // Levels are active low as driven by the board
  assign {o_break_in_strap_n, o_test_mode_strap_n, o_hw_boot_config_code} = straps_r;
endmodule
`default_nettype wire

// ==== tb/bmsd_chk_sva.sv ====
// Checker on the boot selection decoder ports.
// Assumes the clock enable is held high.
`timescale 1ns/100ps
`default_nettype none
module bmsd_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_break_in_strap_n,
  input wire logic        i_test_mode_strap_n,
  input wire logic [2:0]  i_hw_boot_config_code,
  input wire logic        o_valid,
  input wire logic [3:0]  o_action,
  input wire logic [31:0] o_pc_start,
  input wire logic [31:0] o_user_entry,
  input wire logic        o_use_boot_rom,
  input wire logic        o_bsl_async,
  input wire logic        o_bsl_can,
  input wire logic        o_bsl_sync,
  input wire logic        o_ext_bus_master,
  input wire logic        o_ext_bus_slave,
  input wire logic        o_tristate,
  input wire logic        o_stop
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Decode lands one edge after the straps were taken
  sequence cap_async_s;
    $rose(o_valid) ##0 ($past(i_break_in_strap_n) && $past(i_test_mode_strap_n) && $past(i_hw_boot_config_code) == 3'h0);
  endsequence
  sequence cap_tri_s;
    $rose(o_valid) ##0 (!$past(i_break_in_strap_n) && $past(i_test_mode_strap_n) && $past(i_hw_boot_config_code) == 3'h0);
  endsequence
  valid_hold_a: assert property (o_valid |=> o_valid) else $error("valid dropped");
  out_stable_a: assert property (o_valid |=> $stable({o_action, o_pc_start, o_user_entry})) else $error("moved");
  async_pick_a: assert property (cap_async_s |-> o_bsl_async && o_pc_start == 32'hdffffffc
    && o_user_entry == 32'hd4000000) else $error("async boot wrong");
  tri_pick_a: assert property (cap_tri_s |-> o_tristate && !o_use_boot_rom) else $error("tristate wrong");
  bsl_addr_a: assert property (o_valid && (o_bsl_can || o_bsl_sync) |-> o_use_boot_rom
    && o_user_entry == 32'hd4000000) else $error("loader entry wrong");
  ext_addr_a: assert property (o_valid && (o_ext_bus_master || o_ext_bus_slave) |->
    o_pc_start == 32'hdffffffc && o_user_entry == 32'ha0000000) else $error("ext entry wrong");
  scratch_run_a: assert property (o_valid && o_action == 4'h5 |-> o_pc_start == 32'hd4000000
    && !o_use_boot_rom) else $error("scratch start wrong");
  test_stop_a: assert property ($rose(o_valid) && !$past(i_test_mode_strap_n) |-> o_stop)
    else $error("test mode not stopped");
endmodule
bind bmsd_top bmsd_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_break_in_strap_n(i_break_in_strap_n),
  .i_test_mode_strap_n(i_test_mode_strap_n), .i_hw_boot_config_code(i_hw_boot_config_code), .o_valid(o_valid),
  .o_action(o_action), .o_pc_start(o_pc_start), .o_user_entry(o_user_entry), .o_use_boot_rom(o_use_boot_rom),
  .o_bsl_async(o_bsl_async), .o_bsl_can(o_bsl_can), .o_bsl_sync(o_bsl_sync), .o_ext_bus_master(o_ext_bus_master),
  .o_ext_bus_slave(o_ext_bus_slave), .o_tristate(o_tristate), .o_stop(o_stop));
`default_nettype wire

// ==== tb/bmsd_top_bench.sv ====
// Bench for the boot selection decoder: every strap setting, then an upset.
// Assumes the strap model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module bmsd_top_bench;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wig = 1'b0, brk, tm, valid, rom;
  logic [4:0] want = 5'h00;
  logic [2:0] cfg;
  logic [3:0] act;
  logic [31:0] pc, user;
  logic [7:0] fl;
  int checks = 0, fail_count = 0;
  // ==========================================================================
  // Clock, board and design
  always #4 clk = ~clk;
  bmsd_straps u_brd (.i_clk(clk), .i_rst_n(rst_n), .i_want(want), .i_wiggle(wig), .o_break_in_strap_n(brk),
    .o_test_mode_strap_n(tm), .o_hw_boot_config_code(cfg));
  bmsd_top u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_break_in_strap_n(brk), .i_test_mode_strap_n(tm),
    .i_hw_boot_config_code(cfg), .o_valid(valid), .o_action(act), .o_pc_start(pc), .o_user_entry(user),
    .o_use_boot_rom(rom), .o_bsl_async(fl[0]), .o_bsl_can(fl[1]), .o_bsl_sync(fl[2]), .o_ext_bus_master(fl[3]),
    .o_ext_bus_slave(fl[4]), .o_tristate(fl[5]), .o_osc_pll_bypass(fl[6]), .o_stop(fl[7]));
  // Expected action, first fetch, user entry and boot ROM use
  function automatic logic [68:0] exp_of(input logic [4:0] s);
    casez (s)
      5'b110??: return (s[1:0] == 2'b11) ? {4'h3, 32'hdffffffc, 32'ha0000000, 1'b1}
        : {2'b00, s[1:0], 32'hdffffffc, 32'hd4000000, 1'b1};
      5'b11100: return {4'h4, 32'hdffffffc, 32'ha0000000, 1'b1};
      5'b11101, 5'b01010: return {4'h9, 32'h0, 32'h0, 1'b0};
      5'b11110: return {4'h5, 32'hd4000000, 32'hd4000000, 1'b0};
      5'b11111, 5'b10???: return {4'h9, 32'hdffffffc, 32'h0, 1'b1};
      5'b01000: return {4'h7, 32'h0, 32'h0, 1'b0};
      5'b01001: return {4'h6, 32'hdffffffc, 32'hde000000, 1'b1};
      5'b01011: return {4'h8, 32'h0, 32'h0, 1'b0};
      default: return {4'h9, 32'hdfffffff, 32'h0, 1'b1};
    endcase
  endfunction
  // Reset with the given straps, then judge the latched decode
  task automatic boot(input logic [4:0] s);
    logic [68:0] e;
    logic [3:0] a;
    e = exp_of(s);
    a = e[68:65];
    @(posedge clk);
    rst_n <= 1'b0;
    want <= s;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    `CHK("valid", 1'b1, valid)
    `CHK("decode", exp_of(s), {act, pc, user, rom})
    `CHK("flags", (a < 4'h5) ? 8'h01 << a : (a > 4'h6) ? 8'h01 << (a - 4'h2) : 8'h00, fl)
  endtask
  task automatic t_plain;
    for (int i = 0; i < 8; i++) boot({2'b11, i[2:0]});
    $display("done plain");
  endtask
  task automatic t_test;
    for (int i = 0; i < 8; i++) boot({2'b10, i[2:0]});
    $display("done test mode");
  endtask
  task automatic t_brk;
    for (int i = 0; i < 8; i++) boot({2'b01, i[2:0]});
    for (int i = 0; i < 8; i++) boot({2'b00, i[2:0]});
    $display("done break-in");
  endtask
  // Clock enable low across release defers the capture until it rises
  task automatic t_ce;
    logic [68:0] e;
    e = exp_of(5'b11001);
    @(posedge clk);
    rst_n <= 1'b0;
    ce <= 1'b0;
    want <= 5'b11001;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    `CHK("frozen valid", 1'b0, valid)
    `CHK("frozen action", 4'h9, act)
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("thawed valid", 1'b1, valid)
    `CHK("thawed decode", e, {act, pc, user, rom})
    $display("done clock enable");
  endtask
  task automatic t_hold;
    boot(5'b11011);
    @(posedge clk);
    wig <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK("held", exp_of(5'b11011), {act, pc, user, rom})
    @(posedge clk);
    wig <= 1'b0;
    $display("done hold");
  endtask
  task automatic print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the 33 boots of about ten cycles each
  initial
  begin
    #20000;
    fail_count++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    t_plain();
    t_test();
    t_brk();
    t_ce();
    t_hold();
    print_verdict();
  end
endmodule
`default_nettype wire
